// >>> fllic_pkg.sv
// Operation
// [RULE1] block index is 10 bits, blocks 0..1023
// [RULE2] direction 1 starts receive link read
// [RULE3] direction 0 writes link data into RAM
// [RULE4] bit 15 busy while indirect access runs
// [RULE5] link entry never points to itself
// [RULE6] threshold sets blocks filled before DMA drains
// [RULE7] threshold between 1 and N-1, never zero; code refuses only zero, no upper bound check
// [RULE8] channel index is low 8 bits, 256 channels
// [RULE9] threshold read: busy until data readable
// [RULE10] threshold write: direction 0 copies data register
// [RULE11] start pointer write uses direction 1
// [RULE12] start block is any block of chain
// [RULE13] start pointer read returns live block
// [RULE14] device updates start pointer as blocks consumed
// [RULE15] threshold select at 0920h, fields 7..0,14,15
// [RULE16] start pointer select at 0980h
// [RULE17] transmit link select at 0990h, 10-bit index
// [RULE18] DMA drains channel FIFO completely once started
// [RULE19] end of frame triggers transfer before threshold
// [RULE20] wait busy clear before next access
package fllic_pkg;
  localparam logic [11:0] RX_LINK_SELECT_ADDR = 12'h910;
  localparam logic [11:0] RX_LINK_ENTRY_DATA_ADDR = 12'h914;
  localparam logic [11:0] RX_THRESHOLD_SELECT_ADDR = 12'h920;
  localparam logic [11:0] RX_THRESHOLD_DATA_ADDR = 12'h924;
  localparam logic [11:0] TX_FIRST_BLOCK_SELECT_ADDR = 12'h980;
  localparam logic [11:0] TX_FIRST_BLOCK_DATA_ADDR = 12'h984;
  localparam logic [11:0] TX_LINK_SELECT_ADDR = 12'h990;
  localparam logic [11:0] TX_LINK_DATA_ADDR = 12'h994;
  localparam int ACCESS_BUSY_BIT = 15;
  localparam int ACCESS_DIRECTION_BIT = 14;
  localparam int BLOCK_INDEX_W = 10;
  localparam int CHANNEL_INDEX_W = 8;
  localparam int REG_DATA_W = 16;
  localparam logic [15:0] POLL_LIMIT_DEFAULT = 16'h0400;

  typedef enum logic [2:0] {
    OP_RX_LINK_READ,
    OP_RX_LINK_WRITE,
    OP_RX_THRESHOLD_READ,
    OP_RX_THRESHOLD_WRITE,
    OP_TX_START_WRITE,
    OP_TX_START_READ,
    OP_TX_LINK_READ,
    OP_TX_LINK_WRITE
  } fllic_op_t;
endpackage : fllic_pkg

// >>> fllic_host.sv
module fllic_host #(
  parameter logic [15:0] POLL_LIMIT = fllic_pkg::POLL_LIMIT_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user command
  input wire logic cmdValid,
  output logic cmdReady,
  input wire fllic_pkg::fllic_op_t cmdOp,
  input wire logic [9:0] cmdIndex,
  input wire logic [9:0] cmdData,
  // user response
  output logic rspValid,
  output logic [9:0] rspData,
  output logic rspError,
  output logic rspTimeout,
  // device register port
  output logic regReq,
  output logic regWe,
  output logic [11:0] regAddr,
  output logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regAck
);
  typedef enum logic [2:0] {S_IDLE, S_WDATA, S_WSEL, S_POLL, S_RDATA} fllic_state_t;

  fllic_state_t state, next_state;
  fllic_pkg::fllic_op_t op, next_op;
  logic [9:0] index, next_index;
  logic [9:0] data, next_data;
  logic [15:0] pollCount, next_pollCount;
  logic next_regReq, next_regWe;
  logic [11:0] next_regAddr;
  logic [15:0] next_regWrData;
  logic next_rspValid, next_rspError, next_rspTimeout;
  logic [9:0] next_rspData;

  function automatic logic [11:0] selAddr(input fllic_pkg::fllic_op_t o);
    case (o)
      fllic_pkg::OP_RX_LINK_READ, fllic_pkg::OP_RX_LINK_WRITE: selAddr = fllic_pkg::RX_LINK_SELECT_ADDR;
      fllic_pkg::OP_RX_THRESHOLD_READ, fllic_pkg::OP_RX_THRESHOLD_WRITE:
        selAddr = fllic_pkg::RX_THRESHOLD_SELECT_ADDR; // [RULE15]
      fllic_pkg::OP_TX_START_WRITE, fllic_pkg::OP_TX_START_READ:
        selAddr = fllic_pkg::TX_FIRST_BLOCK_SELECT_ADDR; // [RULE16]
      default: selAddr = fllic_pkg::TX_LINK_SELECT_ADDR; // [RULE17]
    endcase
  endfunction : selAddr

  function automatic logic [11:0] dataAddr(input fllic_pkg::fllic_op_t o);
    case (o)
      fllic_pkg::OP_RX_LINK_READ, fllic_pkg::OP_RX_LINK_WRITE: dataAddr = fllic_pkg::RX_LINK_ENTRY_DATA_ADDR;
      fllic_pkg::OP_RX_THRESHOLD_READ, fllic_pkg::OP_RX_THRESHOLD_WRITE:
        dataAddr = fllic_pkg::RX_THRESHOLD_DATA_ADDR;
      fllic_pkg::OP_TX_START_WRITE, fllic_pkg::OP_TX_START_READ: dataAddr = fllic_pkg::TX_FIRST_BLOCK_DATA_ADDR;
      default: dataAddr = fllic_pkg::TX_LINK_DATA_ADDR;
    endcase
  endfunction : dataAddr

  // indirect reads need the data register fetched after busy clears
  function automatic logic isRead(input fllic_pkg::fllic_op_t o);
    isRead = (o == fllic_pkg::OP_RX_LINK_READ) || (o == fllic_pkg::OP_RX_THRESHOLD_READ) ||
             (o == fllic_pkg::OP_TX_LINK_READ) || (o == fllic_pkg::OP_TX_START_READ);
  endfunction : isRead

  function automatic logic isChannel(input fllic_pkg::fllic_op_t o);
    isChannel = (o == fllic_pkg::OP_RX_THRESHOLD_READ) || (o == fllic_pkg::OP_RX_THRESHOLD_WRITE) ||
                (o == fllic_pkg::OP_TX_START_WRITE) || (o == fllic_pkg::OP_TX_START_READ);
  endfunction : isChannel

  // start pointer write is the odd one: direction 1 means write
  function automatic logic dirBit(input fllic_pkg::fllic_op_t o);
    dirBit = (o == fllic_pkg::OP_TX_START_WRITE) ? 1'b1 : isRead(o); // [RULE2] [RULE3] [RULE9] [RULE10] [RULE11]
  endfunction : dirBit

  function automatic logic badCommand(input fllic_pkg::fllic_op_t o, input logic [9:0] idx, input logic [9:0] d);
    badCommand = 1'b0;
    if ((o == fllic_pkg::OP_RX_LINK_WRITE || o == fllic_pkg::OP_TX_LINK_WRITE) && d == idx)
      badCommand = 1'b1; // [RULE5]
    if (o == fllic_pkg::OP_RX_THRESHOLD_WRITE && d == 10'h000)
      badCommand = 1'b1; // [RULE7]
  endfunction : badCommand

  assign cmdReady = (state == S_IDLE);

  always_comb
  begin
    next_state = state;
    next_op = op;
    next_index = index;
    next_data = data;
    next_pollCount = pollCount;
    next_regReq = regReq;
    next_regWe = regWe;
    next_regAddr = regAddr;
    next_regWrData = regWrData;
    next_rspValid = 1'b0;
    next_rspError = rspError;
    next_rspTimeout = rspTimeout;
    next_rspData = rspData;
    case (state)
      S_IDLE:
      begin
        if (cmdValid)
        begin
          next_op = cmdOp;
          // channel ops carry only 8 index bits
          next_index = isChannel(cmdOp) ? {2'h0, cmdIndex[fllic_pkg::CHANNEL_INDEX_W-1:0]} : cmdIndex; // [RULE1] [RULE8]
          next_data = cmdData;
          next_pollCount = 16'h0000;
          if (badCommand(cmdOp, cmdIndex, cmdData))
          begin
            next_rspValid = 1'b1;
            next_rspError = 1'b1;
            next_rspTimeout = 1'b0;
          end
          else if (cmdOp == fllic_pkg::OP_TX_START_READ)
            next_state = S_RDATA; // [RULE13]
          else if (isRead(cmdOp))
            next_state = S_WSEL;
          else
            next_state = S_WDATA;
        end
      end
      S_WDATA:
      begin
        if (!regReq)
        begin
          next_regReq = 1'b1;
          next_regWe = 1'b1;
          next_regAddr = dataAddr(op);
          next_regWrData = {6'h00, data}; // [RULE12]
        end
        else if (regAck)
        begin
          next_regReq = 1'b0;
          next_state = S_WSEL;
        end
      end
      S_WSEL:
      begin
        if (!regReq)
        begin
          next_regReq = 1'b1;
          next_regWe = 1'b1;
          next_regAddr = selAddr(op);
          next_regWrData = {1'b0, dirBit(op), 4'h0, index}; // [RULE2] [RULE3] [RULE11]
        end
        else if (regAck)
        begin
          next_regReq = 1'b0;
          next_state = S_POLL;
        end
      end
      S_POLL:
      begin
        if (!regReq)
        begin
          next_regReq = 1'b1;
          next_regWe = 1'b0;
          next_regAddr = selAddr(op);
        end
        else if (regAck)
        begin
          next_regReq = 1'b0;
          if (regRdData[fllic_pkg::ACCESS_BUSY_BIT])
          begin
            // a hung device must not wedge the controller forever
            if (pollCount == POLL_LIMIT - 16'h0001)
            begin
              next_state = S_IDLE;
              next_rspValid = 1'b1;
              next_rspError = 1'b0;
              next_rspTimeout = 1'b1;
            end
            else
              next_pollCount = pollCount + 16'h0001;
          end
          else if (isRead(op))
            next_state = S_RDATA; // [RULE4] [RULE20]
          else
          begin
            next_state = S_IDLE; // [RULE20]
            next_rspValid = 1'b1;
            next_rspError = 1'b0;
            next_rspTimeout = 1'b0;
          end
        end
      end
      S_RDATA:
      begin
        if (!regReq)
        begin
          next_regReq = 1'b1;
          next_regWe = 1'b0;
          next_regAddr = dataAddr(op);
        end
        else if (regAck)
        begin
          next_regReq = 1'b0;
          next_state = S_IDLE;
          next_rspValid = 1'b1;
          next_rspError = 1'b0;
          next_rspTimeout = 1'b0;
          next_rspData = regRdData[fllic_pkg::BLOCK_INDEX_W-1:0];
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      op <= fllic_pkg::OP_RX_LINK_READ;
      index <= 10'h000;
      data <= 10'h000;
      pollCount <= 16'h0000;
      regReq <= 1'b0;
      regWe <= 1'b0;
      regAddr <= 12'h000;
      regWrData <= 16'h0000;
      rspValid <= 1'b0;
      rspError <= 1'b0;
      rspTimeout <= 1'b0;
      rspData <= 10'h000;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      index <= next_index;
      data <= next_data;
      pollCount <= next_pollCount;
      regReq <= next_regReq;
      regWe <= next_regWe;
      regAddr <= next_regAddr;
      regWrData <= next_regWrData;
      rspValid <= next_rspValid;
      rspError <= next_rspError;
      rspTimeout <= next_rspTimeout;
      rspData <= next_rspData;
    end
  end

  sel_direction_a: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    (state == S_WSEL && regReq) |-> regWrData[fllic_pkg::ACCESS_DIRECTION_BIT] == dirBit(op))
    else $error("select direction bit wrong for operation");
  sel_index_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    (state == S_WSEL && regReq) |-> regWrData[9:0] == index && regWrData[13:10] == 4'h0)
    else $error("select index field wrong");
  channel_width_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    (state == S_WSEL && regReq && isChannel(op)) |-> regWrData[9:8] == 2'h0)
    else $error("channel index wider than 8 bits");
  busy_untouched_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    (state == S_WSEL && regReq) |-> !regWrData[fllic_pkg::ACCESS_BUSY_BIT])
    else $error("busy bit driven on select write");
  poll_busy_a: assert property (@(posedge clk) disable iff (reset) // [RULE20]
    (state == S_POLL && regReq && regAck && regRdData[15] && pollCount != POLL_LIMIT - 16'h0001)
    |=> state == S_POLL ##1 (regReq && !regWe && regAddr == selAddr(op)))
    else $error("left polling while busy");
  poll_done_a: assert property (@(posedge clk) disable iff (reset) // [RULE9]
    (state == S_POLL && regReq && regAck && !regRdData[15]) |=> (isRead(op) ? state == S_RDATA : rspValid))
    else $error("busy clear not acted on");
  zero_threshold_a: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    (cmdValid && cmdReady && cmdOp == fllic_pkg::OP_RX_THRESHOLD_WRITE && cmdData == 10'h000)
    |=> rspValid && rspError && state == S_IDLE)
    else $error("zero threshold not refused");
  self_link_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    (cmdValid && cmdReady && cmdOp == fllic_pkg::OP_RX_LINK_WRITE && cmdData == cmdIndex)
    |=> rspValid && rspError && !regReq)
    else $error("self pointing link not refused");
  threshold_data_a: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    (state == S_WDATA && regReq && op == fllic_pkg::OP_RX_THRESHOLD_WRITE)
    |-> regWe && regAddr == 12'h924 && regWrData == {6'h00, data})
    else $error("threshold data write misplaced");
  start_read_a: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    (cmdValid && cmdReady && cmdOp == fllic_pkg::OP_TX_START_READ) |=> state == S_RDATA ##1 regAddr == 12'h984)
    else $error("start pointer read went through select");
  rsp_pulse_a: assert property (@(posedge clk) disable iff (reset)
    rspValid |=> !rspValid)
    else $error("response longer than one cycle");
  tx_self_link_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    (cmdValid && cmdReady && cmdOp == fllic_pkg::OP_TX_LINK_WRITE && cmdData == cmdIndex)
    |=> rspValid && rspError && !regReq)
    else $error("self pointing transmit link not refused");
  start_write_dir_a: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    (state == S_WSEL && regReq && op == fllic_pkg::OP_TX_START_WRITE) |-> regWrData[fllic_pkg::ACCESS_DIRECTION_BIT])
    else $error("start pointer write sent with direction 0");
  // the device may stretch any access, so the request must stay put
  req_hold_a: assert property (@(posedge clk) disable iff (reset)
    (regReq && !regAck) |=> regReq && $stable(regWe) && $stable(regAddr) && $stable(regWrData))
    else $error("register request changed before acknowledge");
  idle_quiet_a: assert property (@(posedge clk) disable iff (reset) // [RULE20]
    (state == S_IDLE) |-> !regReq)
    else $error("register access outside a command");
  data_read_addr_a: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    (state == S_RDATA && regReq) |-> !regWe && regAddr == dataAddr(op))
    else $error("data register read misplaced");
endmodule : fllic_host

// >>> fllic_dev_model.sv
module fllic_dev_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic regReq,
  input wire logic regWe,
  input wire logic [11:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regAck,
  // pacing set by the bench
  input wire logic [1:0] ackDelay,
  input wire logic [1:0] busyPolls,
  input wire logic stuck
);
  timeunit 1ns;
  timeprecision 1ps;
  // no dma or hdlc engines here, so the live pointer only moves on writes
  logic [9:0] rxLink [1024];
  logic [9:0] txLink [1024];
  logic [9:0] thr [256];
  logic [9:0] txStart [256];
  logic [9:0] dataReg [4];
  logic [15:0] sel [4];
  logic [1:0] cnt;
  logic [1:0] busy;
  logic [7:0] liveCh;
  logic [1:0] slot;
  logic [9:0] idx;
  logic [7:0] ch;
  logic dir;
  assign slot = {regAddr[7], regAddr[7] ? regAddr[4] : regAddr[5]};
  assign idx = regWrData[9:0];
  assign ch = regWrData[7:0];
  assign dir = regWrData[14];
  always_ff @(posedge clk)
  begin
    regAck <= 1'b0;
    // released bus inverts every bit each cycle, so the last word shows again on alternate cycles
    regRdData <= ~regRdData;
    if (reset)
    begin
      cnt <= 2'h0;
      busy <= 2'h0;
      regRdData <= 16'h0;
    end
    else if (regReq && !regAck && cnt != ackDelay)
      cnt <= cnt + 2'h1;
    else if (regReq && !regAck)
    begin
      cnt <= 2'h0;
      regAck <= 1'b1;
      if (regWe && !regAddr[2])
      begin
        sel[slot] <= {2'h0, regWrData[13:0]};
        busy <= busyPolls;
        if (slot == 2'h0 && dir) dataReg[0] <= rxLink[idx];
        if (slot == 2'h0 && !dir) rxLink[idx] <= dataReg[0];
        if (slot == 2'h1 && dir) dataReg[1] <= thr[ch];
        // threshold only stored and read back; fill and drain are not modelled
        if (slot == 2'h1 && !dir) thr[ch] <= dataReg[1];
        if (slot == 2'h2 && dir) txStart[ch] <= dataReg[2];
        if (slot == 2'h2 && dir) liveCh <= ch;
        if (slot == 2'h3 && dir) dataReg[3] <= txLink[idx];
        if (slot == 2'h3 && !dir) txLink[idx] <= dataReg[3];
      end
      else if (regWe)
        dataReg[slot] <= regWrData[9:0];
      else if (!regAddr[2])
      begin
        regRdData <= {busy != 2'h0 || stuck, sel[slot][14:0]};
        if (busy != 2'h0) busy <= busy - 2'h1;
      end
      else
        regRdData <= {6'h0, slot == 2'h2 ? txStart[liveCh] : dataReg[slot]};
    end
  end
endmodule : fllic_dev_model

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [9:0] d;
    logic chk;
    logic e;
    logic t;
  } fllic_exp_t;
  logic clk, reset, cmdValid, cmdReady, rspValid, rspError, rspTimeout, regReq, regWe, regAck, stuck;
  logic [9:0] cmdIndex, cmdData, rspData, idx, v, th;
  logic [11:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic [1:0] ackDelay, busyPolls;
  fllic_pkg::fllic_op_t cmdOp;
  int errors, checkCount, reqCount, n;
  fllic_exp_t expQ[$];
  fllic_exp_t x;
  fllic_host #(.POLL_LIMIT(16'h0004)) dut (.clk, .reset, .cmdValid, .cmdReady, .cmdOp, .cmdIndex, .cmdData,
    .rspValid, .rspData, .rspError, .rspTimeout, .regReq, .regWe, .regAddr, .regWrData, .regRdData, .regAck);
  fllic_dev_model model (.clk, .reset, .regReq, .regWe, .regAddr, .regWrData, .regRdData, .regAck,
    .ackDelay, .busyPolls, .stuck);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(string name, logic [9:0] exp, logic [9:0] got);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic finish_test;
    if (errors == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic run(fllic_pkg::fllic_op_t op, logic [9:0] i, logic [9:0] d, logic [9:0] e, logic c,
    logic er, logic t);
    int k;
    expQ.push_back({e, c, er, t});
    ackDelay <= 2'($urandom_range(3));
    busyPolls <= 2'($urandom_range(2));
    cmdOp <= op;
    cmdIndex <= i;
    cmdData <= d;
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      if (k == 1) check("cmdReady", {9'h0, er}, {9'h0, cmdReady});
    end
    while (rspValid !== 1'b1 && k < 300);
    if (k >= 300) check("rspValid", 10'h1, 10'h0);
  endtask : run
  always @(posedge clk)
  begin
    if (regReq && regAck) reqCount++;
    if (!reset && rspValid === 1'b1)
    begin
      if (expQ.size() == 0) check("rspValid", 10'h0, 10'h1);
      else
      begin
        x = expQ.pop_front();
        check("rspError", {9'h0, x.e}, {9'h0, rspError});
        check("cmdReady", 10'h1, {9'h0, cmdReady});
        check("rspTimeout", {9'h0, x.t}, {9'h0, rspTimeout});
        if (x.chk) check("rspData", x.d, rspData);
      end
    end
  end
  initial
  begin
    {cmdValid, stuck, ackDelay, busyPolls, cmdIndex, cmdData} = '0;
    cmdOp = fllic_pkg::OP_RX_LINK_READ;
    reset = 1'b1;
    errors = 0;
    checkCount = 0;
    reqCount = 0;
    n = $urandom(32'ha765);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // receive and transmit link rams get different values so a swapped address shows up
    for (int i = 0; i < 6; i++)
    begin
      idx = i == 0 ? 10'h000 : i == 1 ? 10'h3ff : 10'($urandom);
      v = idx ^ 10'h155;
      th = {v[9:1], 1'b1};
      run(fllic_pkg::OP_RX_LINK_WRITE, idx, v, 10'h0, 0, 0, 0);
      run(fllic_pkg::OP_TX_LINK_WRITE, idx, ~v, 10'h0, 0, 0, 0);
      run(fllic_pkg::OP_RX_LINK_READ, idx, 10'h0, v, 1, 0, 0);
      run(fllic_pkg::OP_TX_LINK_READ, idx, 10'h0, ~v, 1, 0, 0);
      run(fllic_pkg::OP_RX_THRESHOLD_WRITE, idx, th, 10'h0, 0, 0, 0);
      run(fllic_pkg::OP_TX_START_WRITE, idx, v, 10'h0, 0, 0, 0);
      run(fllic_pkg::OP_RX_THRESHOLD_READ, idx ^ 10'h300, 10'h0, th, 1, 0, 0);
      run(fllic_pkg::OP_TX_START_READ, idx, 10'h0, v, 1, 0, 0);
    end
    n = reqCount;
    run(fllic_pkg::OP_RX_LINK_WRITE, 10'h2a5, 10'h2a5, 10'h0, 0, 1, 0);
    run(fllic_pkg::OP_TX_LINK_WRITE, 10'h3ff, 10'h3ff, 10'h0, 0, 1, 0);
    run(fllic_pkg::OP_RX_THRESHOLD_WRITE, 10'h007, 10'h000, 10'h0, 0, 1, 0);
    check("regAccesses", 10'(n), 10'(reqCount));
    stuck <= 1'b1;
    run(fllic_pkg::OP_RX_LINK_READ, 10'h001, 10'h0, 10'h0, 0, 0, 1);
    stuck <= 1'b0;
    run(fllic_pkg::OP_RX_LINK_READ, 10'h3ff, 10'h0, 10'h3ff ^ 10'h155, 1, 0, 0);
    finish_test();
  end
  initial
  begin
    #200000;
    errors++;
    finish_test();
  end
endmodule : tb
